// [bench/cw_lo_phase_generator_bench.sv]
// self-checking bench for the lo phase generator
`timescale 1ns/10ps
`default_nettype none
`include "cwlo_defs.svh"
module cw_lo_phase_generator_bench;
  import cwlo_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwr = 1'b0, hs;
  logic [1:0] htr = 2'h0;
  logic [31:0] hadr = 32'h0, hwd = 32'h0, rd;
  logic [63:0] psel = 64'h0;
  cwlo_mode_t md = 2'h0;
  wire [31:0] hrd;
  wire hrdy, hresp, nx, sy, hsup;
  wire [15:0] loi, loq;
  wire [127:0] wc, ws;
  int q, n = 16, n_fail = 0, checks_done = 0, cyc = 0;
  always #5 clk = ~clk;
  cwlo_top u_cwlo_top (.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .HSEL_IN(hsel),
    .HADDR_IN(hadr), .HTRANS_IN(htr), .HWRITE_IN(hwr), .HSIZE_IN(3'h2),
    .HWDATA_IN(hwd), .HREADY_IN(hrdy), .HRDATA_OUT(hrd),
    .HREADYOUT_OUT(hrdy), .HRESP_OUT(hresp),
    .CW_MULTIPLE_RATE_CLOCK_IN(nx), .CW_MIXING_RATE_CLOCK_IN(sy),
    .LO_I_OUT(loi), .LO_Q_OUT(loq), .LO_WCOS_OUT(wc), .LO_WSIN_OUT(ws),
    .HSUP_EN_OUT(hsup));
  cwlo_clk_src u_cwlo_clk_src (.mode_in(md), .nx_out(nx), .sync_out(sy),
    .q_out(q));
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [127:0] e, g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  // single word transfer; waits on hready rather than assuming zero wait
  task automatic ahb(input logic w, input logic [31:0] a, d);
    hsel <= 1'b1; htr <= 2'h2; hadr <= a; hwr <= w;
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0; htr <= 2'h0; hwd <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrd;
  endtask
  // {i, q, cos, sin} of one channel at quarter k of the source
  function automatic logic [17:0] exp_ch(cwlo_mode_t m, logic [3:0] p,
      int k);
    logic [3:0] b, d;
    logic i, qq, x, y;
    int nn;
    nn = 16 >> m;
    x = (k % 4) < 2;
    y = (k % 4 == 3) || (k % 4 == 0);
    b = (m == 2'h0) ? p : (m == 2'h1) ? (p & 4'he) : (p & 4'hc);
    d = 4'(((k / 4) % nn) * 16 / nn) - b;
    i = ~d[3];
    d = d + 4'h4;
    qq = ~d[3];
    if (m == `CWLO_MODE_1X) begin
      case (b[3:2])
        2'h0: {i, qq} = {x, y};
        2'h1: {i, qq} = {~y, x};
        2'h2: {i, qq} = {~x, ~y};
        default: {i, qq} = {y, ~x};
      endcase
    end
    case (p - b)
      4'h0: exp_ch = {i, qq, 16'hff00};
      4'h1: exp_ch = {i, qq, 16'hed62};
      4'h2: exp_ch = {i, qq, 16'hb5b5};
      default: exp_ch = {i, qq, 16'h62ed};
    endcase
  endfunction
  // one full source period (two in one-times mode), sampled late in each quarter
  task automatic check_lo;
    logic [15:0] ei, eq;
    logic [127:0] ec, es;
    repeat (4 * n) begin
      @(q);
      repeat (7) @(posedge clk);
      for (int c = 0; c < 16; c++) begin
        {ei[c], eq[c], ec[8*c +: 8], es[8*c +: 8]} =
          exp_ch(md, psel[4*c +: 4], q);
      end
      chk("lo i", ei, loi);
      chk("lo q", eq, loq);
      chk("cos", ec, wc);
      chk("sin", es, ws);
    end
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      $display("timeout");
      results();
    end
  end
  initial begin
    void'($urandom(32'ha919d20d));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    ahb(1'b1, 32'h10, 32'hffffffff);
    ahb(1'b1, `CWLO_STAT_OFS, 32'h3);
    for (int a = 0; a < 5; a++) begin
      ahb(1'b0, 32'(4 * a), 32'h0);
      chk("reset read", 128'h0, a == 1 ? rd[2:0] : rd);
    end
    check_lo();
    $display("test reset done");
    for (int m = 0; m < 4; m++) begin
      psel = (m == 0) ? 64'hfedcba9876543210
        : {32'($urandom), 32'($urandom) & 32'hfffffff0};
      hs = 1'($urandom);
      ahb(1'b1, `CWLO_PSEL_LO_OFS, psel[31:0]);
      ahb(1'b1, `CWLO_PSEL_HI_OFS, psel[63:32]);
      ahb(1'b1, `CWLO_CTRL_OFS, {29'h0, hs, 2'(m)});
      ahb(1'b0, `CWLO_CTRL_OFS, 32'h0);
      chk("ctrl", {29'h0, hs, 2'(m)}, rd);
      ahb(1'b0, `CWLO_PSEL_HI_OFS, 32'h0);
      chk("psel", psel[63:32], rd);
      md <= 2'(m);
      n = 16 >> m;
      repeat (8 * n + 2) @(q);
      @(posedge clk);
      ahb(1'b0, `CWLO_STAT_OFS, 32'h0);
      chk("status", {hs && m < 2, 2'(m)}, rd[2:0]);
      chk("hsup", hs && m < 2, hsup);
      check_lo();
      $display("test mode %0d done", m);
    end
    results();
  end
endmodule
`default_nettype wire

// [bench/cwlo_clk_src.sv]
// external clock source model: n-times and sync clocks, or i/q pair
`timescale 1ns/10ps
`default_nettype none
`include "cwlo_defs.svh"
module cwlo_clk_src (
  // mode set by the bench
  input wire cwlo_pkg::cwlo_mode_t mode_in,
  // clock pins and quarter index
  output logic nx_out,
  output logic sync_out,
  output int q_out
);
  import cwlo_pkg::*;
  int n;
  // 80 ns quarters: slow enough for the core to sample each phase
  initial begin
    q_out = 0;
    #3;
    forever begin
      n = 16 >> mode_in;
      nx_out = (q_out % 4) < 2;
      if (mode_in == `CWLO_MODE_1X) begin
        sync_out = (q_out % 4 == 3) || (q_out % 4 == 0);
      end else begin
        sync_out = ((q_out / 4) % n) < n / 2;
      end
      #80 q_out = q_out + 1;
    end
  end
endmodule
`default_nettype wire

// [bench/cwlo_monitor.sv]
// port checker for the lo phase generator
`timescale 1ns/10ps
`default_nettype none
module cwlo_monitor (
  // clock, reset and bus
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic HSEL_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic HREADY_IN,
  input wire logic [31:0] HRDATA_OUT,
  input wire logic HREADYOUT_OUT,
  input wire logic HRESP_OUT,
  // clock pins and lo outputs
  input wire logic CW_MULTIPLE_RATE_CLOCK_IN,
  input wire logic CW_MIXING_RATE_CLOCK_IN,
  input wire logic [15:0] LO_I_OUT,
  input wire logic [15:0] LO_Q_OUT,
  input wire logic [127:0] LO_WCOS_OUT,
  input wire logic [127:0] LO_WSIN_OUT,
  input wire logic HSUP_EN_OUT
);
  logic sy_q;
  logic [3:0] age_q;
  wire rd_go = HSEL_IN && HTRANS_IN[1] && HREADY_IN && !HWRITE_IN;
  wire [15:0] w15 = {LO_WCOS_OUT[127:120], LO_WSIN_OUT[127:120]};
  // cycles since a sync pin rise, saturating so it never wraps
  always_ff @(posedge CORE_CLK_IN) begin
    sy_q <= CW_MIXING_RATE_CLOCK_IN;
    if (!RST_N_IN) age_q <= 4'hf;
    else if (CW_MIXING_RATE_CLOCK_IN && !sy_q) age_q <= 4'h0;
    else if (age_q != 4'hf) age_q <= age_q + 4'h1;
  end
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // long enough for the pin synchronisers and output register to settle
  sequence pins_quiet;
    (RST_N_IN && $stable(CW_MULTIPLE_RATE_CLOCK_IN)
      && $stable(CW_MIXING_RATE_CLOCK_IN))[*8];
  endsequence
  okay_resp_a: assert property (HRESP_OUT == 1'b0)
    else $error("response not okay");
  zero_wait_a: assert property (HREADYOUT_OUT == 1'b1)
    else $error("wait state inserted");
  rdata_idle_a: assert property (!rd_go |=> HRDATA_OUT == 32'h0)
    else $error("read data outside read");
  reset_quiet_a: assert property (disable iff (1'b0)
    !RST_N_IN |=> LO_I_OUT == 16'h0 && HSUP_EN_OUT == 1'b0)
    else $error("outputs active in reset");
  quad_lead_a: assert property ($rose(LO_I_OUT[0]) |-> LO_Q_OUT[0])
    else $error("quadrature not leading");
  quiet_hold_a: assert property (pins_quiet |-> $stable(LO_I_OUT)
    && $stable(LO_Q_OUT) && $stable(LO_WCOS_OUT) && $stable(HSUP_EN_OUT))
    else $error("lo moved without pin edge");
  weight_pair_a: assert property ($past(RST_N_IN, 3) |->
    w15 inside {16'hff00, 16'hed62, 16'hb5b5, 16'h62ed})
    else $error("weight pair illegal");
  sync_apply_a: assert property ($changed(HSUP_EN_OUT)
    && $past(RST_N_IN) |-> age_q <= 4'h6)
    else $error("config applied without sync");
endmodule
bind cwlo_top cwlo_monitor u_cwlo_monitor (.CORE_CLK_IN, .RST_N_IN,
  .HSEL_IN, .HTRANS_IN, .HWRITE_IN, .HREADY_IN, .HRDATA_OUT,
  .HREADYOUT_OUT, .HRESP_OUT, .CW_MULTIPLE_RATE_CLOCK_IN,
  .CW_MIXING_RATE_CLOCK_IN, .LO_I_OUT, .LO_Q_OUT, .LO_WCOS_OUT,
  .LO_WSIN_OUT, .HSUP_EN_OUT);
`default_nettype wire

// [rtl/cwlo_defs.svh]
// offsets, field positions, reset values and codes of the lo phase generator
`ifndef CWLO_DEFS_SVH
`define CWLO_DEFS_SVH

// register byte offsets
`define CWLO_CTRL_OFS 12'h000
`define CWLO_STAT_OFS 12'h004
`define CWLO_PSEL_LO_OFS 12'h008
`define CWLO_PSEL_HI_OFS 12'h00c

// multiplier mode codes
`define CWLO_MODE_16X 2'h0
`define CWLO_MODE_8X 2'h1
`define CWLO_MODE_4X 2'h2
`define CWLO_MODE_1X 2'h3

// control register fields
`define CWLO_CTRL_MODE_LSB 0
`define CWLO_CTRL_HSUP_BIT 2

// status register fields
`define CWLO_STAT_MODE_LSB 0
`define CWLO_STAT_HSUP_BIT 2
`define CWLO_STAT_PEND_BIT 3
`define CWLO_STAT_POS_LSB 4
`define CWLO_STAT_SYNC_BIT 8

// reset values
`define CWLO_CTRL_RST 3'h0
`define CWLO_PSEL_RST 32'h0000_0000

// number of sixteenth-period steps in one quarter period
`define CWLO_QUARTER 4'h4

`endif

// [rtl/cwlo_pkg.sv]
// types shared by the lo phase generator files
package cwlo_pkg;
  typedef logic [1:0] cwlo_mode_t;
  typedef logic [3:0] cwlo_phase_t;
  typedef logic [7:0] cwlo_weight_t;
endpackage

// [rtl/cwlo_top.sv]
// lo phase generator: ahb-lite registers, divider, sync alignment
`timescale 1ns/10ps
`default_nettype none
`include "cwlo_defs.svh"

// Functional notes
// - reset mode is sixteen-times
// - sixteen-times mode gives sixteen even phases
// - sync clock aligns phase across devices
// - sixteen-by-sixteen cross-point feeds every channel
// - cross-point phases are 22.5 degrees apart
// - each channel gets its programmed delay phase
// - quadrature modes give i/q 90 degrees apart
// - harmonic suppression only in sixteen- and eight-times modes
// - intermediate phases via cosine/sine i/q weights
// - one-times mode demodulates with both inputs
// - divided modes use sync only for alignment
// - lo equals input clock divided by N
// - weighted modes support up to 15 MHz
module cwlo_top (
  // clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  // ahb-lite slave
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  // cw clock pins
  input wire logic CW_MULTIPLE_RATE_CLOCK_IN,
  input wire logic CW_MIXING_RATE_CLOCK_IN,
  // per-channel mixer clocks and weights
  output logic [15:0] LO_I_OUT,
  output logic [15:0] LO_Q_OUT,
  output logic [127:0] LO_WCOS_OUT,
  output logic [127:0] LO_WSIN_OUT,
  output logic HSUP_EN_OUT
);
  import cwlo_pkg::*;

  // register map, one aligned word each:
  //   ctrl     rw  [1:0] multiplier mode, [2] suppression request
  //   status   ro  [1:0] applied mode, [2] suppression in effect,
  //                [3] written config not yet applied,
  //                [7:4] live raw divider count of input edges,
  //                [8] at least one sync edge seen since reset
  //   psel lo  rw  channels 0..7, four bits of phase each
  //   psel hi  rw  channels 8..15, same layout
  // unmapped offsets read zero and ignore writes; the upper
  // address bits are not decoded, so the map repeats every 4 kb
  //
  // mode codes: 0 sixteen-times, 1 eight-times, 2 four-times,
  // 3 one-times; the reset value selects sixteen-times
  //
  // bus timing: the slave never stretches a transfer, so the data
  // phase always follows the address phase directly; read data is
  // registered and stands for that one data phase only, zero after
  //
  // a read right after a write to the same register returns the
  // new value, because the read mux looks at the next-state value
  //
  // pin timing: both cw clock pins pass two flops, then an edge
  // detector on the second and third stage; a pin edge is acted
  // on two to three core cycles after it happens; in divided modes
  // the lo outputs follow one more cycle later through their registers, in one-times mode in that same cycle
  //
  // limitation: the pins are sampled, not used as clocks, so each
  // pin level must last at least three core cycles; real-rate cw
  // clocks need a dedicated clocked divider instead of this model
  //
  // config written by software is only a shadow; it is copied to
  // the applied set on a sync edge, so every device on a shared
  // sync clock switches mode and phases at the same instant
  //
  // in one-times mode the two pins carry the external i and q
  // clocks; the divider is frozen and the lo outputs are quarter
  // turns of that pair, picked by the coarse phase of the channel
  //
  // intermediate phases are not made by the square waves; they are
  // handed to the analog combiner as cos/sin weight codes, which
  // keeps the digital side simple at the cost of 8 bits a weight
  //
  // harmonic suppression is granted in sixteen- and eight-times
  // modes and withheld in four- and one-times, whatever is asked

  // ---------------- bus slave ----------------
  logic wr_pend_q;
  logic [11:0] wr_addr_q;
  logic [2:0] ctrl_q;
  logic [2:0] ctrl_d;
  logic [31:0] psel_lo_q;
  logic [31:0] psel_lo_d;
  logic [31:0] psel_hi_q;
  logic [31:0] psel_hi_d;
  logic [31:0] rdata_q;
  logic pend_q;
  logic [2:0] act_ctrl_q;
  logic [63:0] act_sel_q;
  logic sync_seen_q;
  cwlo_phase_t cnt_q;

  // address phase accepted on a selected nonseq/seq transfer
  wire logic addr_ok = HSEL_IN & HTRANS_IN[1] & HREADY_IN;
  wire logic rd_take = addr_ok & ~HWRITE_IN;
  wire logic wr_take = addr_ok & HWRITE_IN;
  wire logic [11:0] rd_ofs = {HADDR_IN[11:2], 2'b00};

  // write data lands in the data phase
  wire logic wr_ctrl = wr_pend_q & (wr_addr_q == `CWLO_CTRL_OFS);
  wire logic wr_plo = wr_pend_q & (wr_addr_q == `CWLO_PSEL_LO_OFS);
  wire logic wr_phi = wr_pend_q & (wr_addr_q == `CWLO_PSEL_HI_OFS);
  wire logic cfg_wr = wr_ctrl | wr_plo | wr_phi;
  assign ctrl_d = wr_ctrl ? HWDATA_IN[2:0] : ctrl_q;
  assign psel_lo_d = wr_plo ? HWDATA_IN : psel_lo_q;
  assign psel_hi_d = wr_phi ? HWDATA_IN : psel_hi_q;

  // status shows the applied config and live divider phase
  wire logic hsup_eff;
  wire logic [31:0] stat_word = {23'h0, sync_seen_q, cnt_q, pend_q,
                                 hsup_eff, act_ctrl_q[1:0]};

  // read mux uses next values so a read right after a write sees it
  wire logic [31:0] rd_word =
    (rd_ofs == `CWLO_CTRL_OFS) ? {29'h0, ctrl_d} :
    (rd_ofs == `CWLO_STAT_OFS) ? stat_word :
    (rd_ofs == `CWLO_PSEL_LO_OFS) ? psel_lo_d :
    (rd_ofs == `CWLO_PSEL_HI_OFS) ? psel_hi_d : 32'h0000_0000;

  // bus pipeline registers; never waits, always okay
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
      rdata_q <= 32'h0000_0000;
    end else begin
      wr_pend_q <= wr_take;
      wr_addr_q <= {HADDR_IN[11:2], 2'b00};
      rdata_q <= rd_take ? rd_word : 32'h0000_0000;
    end
  end

  // shadow configuration written by software
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      ctrl_q <= `CWLO_CTRL_RST;
      psel_lo_q <= `CWLO_PSEL_RST;
      psel_hi_q <= `CWLO_PSEL_RST;
    end else begin
      ctrl_q <= ctrl_d;
      psel_lo_q <= psel_lo_d;
      psel_hi_q <= psel_hi_d;
    end
  end

  // ---------------- pin synchronisers ----------------
  // pins are asynchronous to the core clock; only stages 2 and 3 are looked at
  logic nx_s1_q;
  logic nx_s2_q;
  logic nx_s3_q;
  logic sy_s1_q;
  logic sy_s2_q;
  logic sy_s3_q;

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      nx_s1_q <= 1'b0;
      nx_s2_q <= 1'b0;
      nx_s3_q <= 1'b0;
      sy_s1_q <= 1'b0;
      sy_s2_q <= 1'b0;
      sy_s3_q <= 1'b0;
    end else begin
      nx_s1_q <= CW_MULTIPLE_RATE_CLOCK_IN;
      nx_s2_q <= nx_s1_q;
      nx_s3_q <= nx_s2_q;
      sy_s1_q <= CW_MIXING_RATE_CLOCK_IN;
      sy_s2_q <= sy_s1_q;
      sy_s3_q <= sy_s2_q;
    end
  end

  // rising edges; the input clock must stay below half the core rate
  wire logic nx_rise = nx_s2_q & ~nx_s3_q;
  wire logic sy_rise = sy_s2_q & ~sy_s3_q;

  // ---------------- apply at sync, divider ----------------
  wire cwlo_mode_t act_mode = act_ctrl_q[1:0];
  wire logic one_x = (act_mode == `CWLO_MODE_1X);

  // suppression offered in 16x and 8x, never in 4x or 1x
  assign hsup_eff = act_ctrl_q[`CWLO_CTRL_HSUP_BIT] &
                    ((act_mode == `CWLO_MODE_16X) |
                     (act_mode == `CWLO_MODE_8X));

  // static config taken over only on a sync edge; a write in that
  // same cycle keeps pending set so it is not lost
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      act_ctrl_q <= `CWLO_CTRL_RST;
      act_sel_q <= 64'h0;
      pend_q <= 1'b0;
      sync_seen_q <= 1'b0;
    end else begin
      if (sy_rise) begin
        act_ctrl_q <= ctrl_q;
        act_sel_q <= {psel_hi_q, psel_lo_q};
        sync_seen_q <= 1'b1;
      end
      pend_q <= cfg_wr | (pend_q & ~sy_rise);
    end
  end

  // divider counts input edges; the mode picks 16, 8 or 4 per turn
  // by how far the count is scaled, so one counter serves all
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      cnt_q <= 4'h0;
    end else if (sy_rise && !one_x) begin
      cnt_q <= 4'h0;
    end else if (nx_rise && !one_x) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  // count scaled to sixteenths of the lo period
  wire cwlo_phase_t pos16 =
    (act_mode == `CWLO_MODE_16X) ? cnt_q :
    (act_mode == `CWLO_MODE_8X) ? {cnt_q[2:0], 1'b0} :
    {cnt_q[1:0], 2'b00};

  // ---------------- cross-point ----------------
  logic [15:0] lo_i;
  logic [15:0] lo_q;
  logic [127:0] wcos;
  logic [127:0] wsin;

  cwlo_xpt u_xpt (
    .mode_in(act_mode),
    .sel_in(act_sel_q),
    .pos_in(pos16),
    .nx_in(nx_s2_q),
    .sync_in(sy_s2_q),
    .lo_i_out(lo_i),
    .lo_q_out(lo_q),
    .wcos_out(wcos),
    .wsin_out(wsin)
  );

  // output registers; one core cycle behind the divider
  logic [15:0] lo_i_q;
  logic [15:0] lo_q_q;
  logic [127:0] wcos_q;
  logic [127:0] wsin_q;
  logic hsup_q;
  logic hready_q;

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      lo_i_q <= 16'h0000;
      lo_q_q <= 16'h0000;
      wcos_q <= 128'h0;
      wsin_q <= 128'h0;
      hsup_q <= 1'b0;
      hready_q <= 1'b1;
    end else begin
      lo_i_q <= lo_i;
      lo_q_q <= lo_q;
      wcos_q <= wcos;
      wsin_q <= wsin;
      hsup_q <= hsup_eff;
      hready_q <= 1'b1;
    end
  end

  assign LO_I_OUT = lo_i_q;
  assign LO_Q_OUT = lo_q_q;
  assign LO_WCOS_OUT = wcos_q;
  assign LO_WSIN_OUT = wsin_q;
  assign HSUP_EN_OUT = hsup_q;
  assign HRDATA_OUT = rdata_q;
  assign HREADYOUT_OUT = hready_q;
  assign HRESP_OUT = 1'b0;
endmodule
`default_nettype wire

// [rtl/cwlo_xpt.sv]
// phase cross-point: one selected lo phase and its weights per channel
`timescale 1ns/10ps
`default_nettype none
`include "cwlo_defs.svh"

module cwlo_xpt (
  // configuration
  input wire cwlo_pkg::cwlo_mode_t mode_in,
  input wire logic [63:0] sel_in,
  // phase sources
  input wire cwlo_pkg::cwlo_phase_t pos_in,
  input wire logic nx_in,
  input wire logic sync_in,
  // per-channel clocks and weights
  output logic [15:0] lo_i_out,
  output logic [15:0] lo_q_out,
  output logic [127:0] wcos_out,
  output logic [127:0] wsin_out
);
  import cwlo_pkg::*;

  // square wave of a sixteenth-step phase: high for the first half period
  function automatic logic square(input cwlo_phase_t pos,
                                  input cwlo_phase_t off);
    cwlo_phase_t d;
    d = pos - off;
    return ~d[3];
  endfunction

  // phase actually available in the mode, rounded down to its step
  function automatic cwlo_phase_t base_of(input cwlo_mode_t m,
                                          input cwlo_phase_t s);
    case (m)
      `CWLO_MODE_16X: base_of = s;
      `CWLO_MODE_8X: base_of = {s[3:1], 1'b0};
      default: base_of = {s[3:2], 2'b00};
    endcase
  endfunction

  // cosine of the residual angle, 256 standing for one, clipped to 255 at zero angle
  function automatic cwlo_weight_t cos_w(input logic [1:0] r);
    case (r)
      2'h0: cos_w = 8'hff;
      2'h1: cos_w = 8'hed;
      2'h2: cos_w = 8'hb5;
      default: cos_w = 8'h62;
    endcase
  endfunction

  // sine of the residual angle
  function automatic cwlo_weight_t sin_w(input logic [1:0] r);
    case (r)
      2'h0: sin_w = 8'h00;
      2'h1: sin_w = 8'h62;
      2'h2: sin_w = 8'hb5;
      default: sin_w = 8'hed;
    endcase
  endfunction

  wire logic one_x = (mode_in == `CWLO_MODE_1X);

  // full 16 x 16 cross-point, any phase to any channel
  for (genvar c = 0; c < 16; c++) begin : g_ch
    wire cwlo_phase_t sel = sel_in[4*c +: 4];
    wire cwlo_phase_t b = base_of(mode_in, sel);
    wire logic [1:0] r = 2'(sel - b);
    wire logic rot_i;
    wire logic rot_q;
    // 1x: quarter turns of the external i/q pair, no division
    assign rot_i = b[3] ? (b[2] ? sync_in : ~nx_in) :
                          (b[2] ? ~sync_in : nx_in);
    assign rot_q = b[3] ? (b[2] ? ~nx_in : ~sync_in) :
                          (b[2] ? nx_in : sync_in);
    // divided phases 22.5 deg apart in 16x, 45 in 8x, 90 in 4x, q leading i by 90 deg
    assign lo_i_out[c] = one_x ? rot_i : square(pos_in, b);
    assign lo_q_out[c] = one_x ? rot_q :
                         square(pos_in, b - `CWLO_QUARTER);
    // in-between angles by cos/sin weighting of i and q
    assign wcos_out[8*c +: 8] = cos_w(r);
    assign wsin_out[8*c +: 8] = sin_w(r);
  end
endmodule
`default_nettype wire
